//--- logic/hpfo_defines.svh
// Register offsets, field positions and reset values of the filter/orientation bank.
// Assumes inclusion by bare name from the package and the design.
`ifndef HPFO_DEFINES_SVH
`define HPFO_DEFINES_SVH
`define HPFO_ADDR_DATA_CFG 8'h0E
`define HPFO_ADDR_HP_CUT 8'h0F
`define HPFO_ADDR_OR_STAT 8'h10
`define HPFO_ADDR_OR_CFG 8'h11
`define HPFO_BIT_HP_OUT 4
`define HPFO_BIT_PULSE_BYP 5
`define HPFO_BIT_PULSE_LPF 4
`define HPFO_BIT_CHANGED 7
`define HPFO_BIT_ZTILT 6
`define HPFO_BIT_DBC_MODE 7
`define HPFO_BIT_OR_EN 6
`define HPFO_DATA_CFG_MASK 8'h13
`define HPFO_HP_CUT_MASK 8'h33
`define HPFO_OR_CFG_MASK 8'hC0
`define HPFO_RST_DATA_CFG 8'h00
`define HPFO_RST_HP_CUT 8'h00
`define HPFO_RST_OR_CFG 8'h80
`endif

//--- logic/hpfo_pkg.sv
// Types shared by the filter/orientation register bank.
// Assumes hpfo_defines.svh is on the include path.
package hpfo_pkg;
    `include "hpfo_defines.svh"
    typedef enum logic [1:0] {
        HPFO_OSR_NORMAL = 2'b00,
        HPFO_OSR_LNLP = 2'b01,
        HPFO_OSR_HIRES = 2'b10,
        HPFO_OSR_LOWPWR = 2'b11
    } hpfo_osr_e;
    typedef struct packed {
        logic [11:0] x;
        logic [11:0] y;
        logic [11:0] z;
    } hpfo_sample_s;
    typedef struct packed {
        logic z_tilt_hold;
        logic [1:0] portrait_landscape_code;
        logic back_front_code;
    } hpfo_orient_s;
endpackage

//--- logic/hpfo_regs.sv
// High-pass filter and orientation configuration/status registers.
// Assumes a serial register engine on SYS_CLK giving one-cycle read and write strobes,
// and filter and orientation-detector datapaths on the same clock.
`timescale 1ns/1ns
`include "hpfo_defines.svh"

module hpfo_regs #(
    parameter int SAMPLE_W = 12
) (
    input wire logic SYS_CLK,
    input wire logic RSTN,
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    input wire logic [2:0] ODR_SEL,
    input wire hpfo_pkg::hpfo_osr_e OSR_MODE,
    output logic [3:0] HP_CUTOFF_SHIFT,
    output logic PULSE_HP_BYPASS,
    output logic PULSE_LP_ENABLE,
    input wire logic SAMPLE_VALID,
    input wire hpfo_pkg::hpfo_sample_s RAW_SAMPLE,
    input wire hpfo_pkg::hpfo_sample_s HP_SAMPLE,
    output hpfo_pkg::hpfo_sample_s OUT_SAMPLE,
    output logic OUT_VALID,
    input wire logic ACTIVE,
    input wire logic WAKE,
    input wire logic DET_VALID,
    input wire hpfo_pkg::hpfo_orient_s DET_ORIENT,
    input wire logic DET_OVER_LIMIT,
    input wire logic [7:0] DEBOUNCE_LIMIT,
    input wire logic ORIENT_IRQ_ENABLE,
    output logic ORIENT_IRQ_SOURCE,
    output logic [7:0] DEBOUNCE_COUNT
);
    import hpfo_pkg::*;

    // The packed sample type carries 12-bit axes only, so other widths are refused here.
    if (SAMPLE_W != 12) begin : g_bad_width
        $error("hpfo_regs supports only 12-bit samples");
    end

    // ==========================================================
    // Register writes
    logic [7:0] data_cfg_q, data_cfg_d;
    logic [7:0] hp_cut_q, hp_cut_d;
    logic [7:0] or_cfg_q, or_cfg_d;

    // Writes to the status register and to unmapped addresses fall through and are dropped.
    always_comb begin
        data_cfg_d = data_cfg_q;
        hp_cut_d = hp_cut_q;
        or_cfg_d = or_cfg_q;
        if (REG_WR) begin
            case (REG_ADDR)
                `HPFO_ADDR_DATA_CFG: data_cfg_d = REG_WDATA & `HPFO_DATA_CFG_MASK;
                `HPFO_ADDR_HP_CUT: hp_cut_d = REG_WDATA & `HPFO_HP_CUT_MASK;
                `HPFO_ADDR_OR_CFG: or_cfg_d = REG_WDATA & `HPFO_OR_CFG_MASK;
                default: ;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            data_cfg_q <= `HPFO_RST_DATA_CFG;
            hp_cut_q <= `HPFO_RST_HP_CUT;
            or_cfg_q <= `HPFO_RST_OR_CFG;
        end else begin
            data_cfg_q <= data_cfg_d;
            hp_cut_q <= hp_cut_d;
            or_cfg_q <= or_cfg_d;
        end
    end

    // ==========================================================
    // Filter control
    // The cutoff is 16 Hz divided by two to the power of the shift.
    // Each table gives the shift of selection code 00 per data rate; the code is added on top.
    function automatic logic [3:0] rate_shift(input logic [2:0] odr, input hpfo_osr_e osr);
        logic [3:0] s;
        s = 4'h0;
        case (osr)
            HPFO_OSR_HIRES: begin
                s = 4'h0;
            end
            HPFO_OSR_LOWPWR: begin
                case (odr)
                    3'h0: s = 4'h0;
                    3'h1: s = 4'h1;
                    3'h2: s = 4'h2;
                    3'h3: s = 4'h3;
                    3'h4: s = 4'h4;
                    default: s = 4'h6;
                endcase
            end
            HPFO_OSR_LNLP: begin
                case (odr)
                    3'h0: s = 4'h0;
                    3'h1: s = 4'h0;
                    3'h2: s = 4'h1;
                    3'h3: s = 4'h2;
                    3'h4: s = 4'h3;
                    default: s = 4'h5;
                endcase
            end
            default: begin
                case (odr)
                    3'h0: s = 4'h0;
                    3'h1: s = 4'h0;
                    3'h2: s = 4'h1;
                    3'h3: s = 4'h2;
                    default: s = 4'h3;
                endcase
            end
        endcase
        return s;
    endfunction

    logic [3:0] shift_q, shift_d;
    hpfo_sample_s out_q, out_d;
    logic out_vld_q, out_vld_d;

    // Output source is muxed per axis, but all three axes follow the one HPFO_BIT_HP_OUT bit of data_cfg_q.
    logic [3*SAMPLE_W-1:0] raw_bits;
    logic [3*SAMPLE_W-1:0] hp_bits;
    logic [3*SAMPLE_W-1:0] pick_bits;

    assign raw_bits = RAW_SAMPLE;
    assign hp_bits = HP_SAMPLE;

    for (genvar ax = 0; ax < 3; ax++) begin : g_axis
        assign pick_bits[ax*SAMPLE_W +: SAMPLE_W] = data_cfg_q[`HPFO_BIT_HP_OUT]
            ? hp_bits[ax*SAMPLE_W +: SAMPLE_W] : raw_bits[ax*SAMPLE_W +: SAMPLE_W];
    end

    // The shift is registered so the filter taps never see a half-updated selection.

    always_comb begin
        shift_d = rate_shift(ODR_SEL, OSR_MODE) + {2'b00, hp_cut_q[1:0]};
        out_d = out_q;
        out_vld_d = SAMPLE_VALID;
        if (SAMPLE_VALID) begin
            out_d = hpfo_sample_s'(pick_bits);
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            shift_q <= 4'h0;
            out_q <= '0;
            out_vld_q <= 1'b0;
        end else begin
            shift_q <= shift_d;
            out_q <= out_d;
            out_vld_q <= out_vld_d;
        end
    end

    assign HP_CUTOFF_SHIFT = shift_q;
    assign OUT_SAMPLE = out_q;
    assign OUT_VALID = out_vld_q;
    assign PULSE_HP_BYPASS = hp_cut_q[`HPFO_BIT_PULSE_BYP];
    assign PULSE_LP_ENABLE = hp_cut_q[`HPFO_BIT_PULSE_LPF];

    // ==========================================================
    // Orientation tracking
    hpfo_orient_s orient_q, orient_d;
    logic changed_q, changed_d;
    logic first_q, first_d;
    logic active_q, active_d;
    logic wake_q, wake_d;
    logic [7:0] dbc_q, dbc_d;
    logic stat_rd;
    logic det_on;
    logic accept;

    assign stat_rd = REG_RD && (REG_ADDR == `HPFO_ADDR_OR_STAT);
    assign det_on = or_cfg_q[`HPFO_BIT_OR_EN];

    always_comb begin
        orient_d = orient_q;
        dbc_d = dbc_q;
        first_d = first_q;
        active_d = ACTIVE;
        wake_d = WAKE;
        accept = 1'b0;
        changed_d = changed_q;
        if (stat_rd) begin
            changed_d = 1'b0;
        end
        // Activation is remembered even while detection is off, until a result is taken.
        if (ACTIVE && !active_q) begin
            first_d = 1'b1;
        end
        // Results taken while disabled, in standby or over the g limit touch nothing.
        if (DET_VALID && det_on && ACTIVE && !DET_OVER_LIMIT) begin
            if (first_q) begin
                accept = 1'b1;
                first_d = 1'b0;
                dbc_d = 8'h00;
            end else if (DET_ORIENT != orient_q) begin
                if (dbc_q >= DEBOUNCE_LIMIT) begin
                    accept = 1'b1;
                    dbc_d = 8'h00;
                end else begin
                    dbc_d = dbc_q + 8'h01;
                end
            end else if (or_cfg_q[`HPFO_BIT_DBC_MODE]) begin
                dbc_d = 8'h00;
            end else if (dbc_q != 8'h00) begin
                dbc_d = dbc_q - 8'h01;
            end
        end
        // A detection in the cycle of a clearing read sets the flag again, so no change is lost.
        if (accept) begin
            // Codes track the detector even while the flag is pending.
            orient_d = DET_ORIENT;
            if (first_q || DET_ORIENT != orient_q) begin
                changed_d = 1'b1;
            end
        end
        // A change of the wake level since the last edge is a wake/sleep transition.
        if (WAKE != wake_q) begin
            dbc_d = 8'h00;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            orient_q <= '0;
            changed_q <= 1'b0;
            first_q <= 1'b0;
            active_q <= 1'b0;
            wake_q <= 1'b0;
            dbc_q <= 8'h00;
        end else begin
            orient_q <= orient_d;
            changed_q <= changed_d;
            first_q <= first_d;
            active_q <= active_d;
            wake_q <= wake_d;
            dbc_q <= dbc_d;
        end
    end

    // Combinational so the source drops in the same cycle that the clearing read lands.
    assign ORIENT_IRQ_SOURCE = changed_q && ORIENT_IRQ_ENABLE;
    assign DEBOUNCE_COUNT = dbc_q;

    // ==========================================================
    // Register reads
    logic [7:0] rdata_q, rdata_d;
    logic [7:0] stat_word;

    assign stat_word = {changed_q, orient_q.z_tilt_hold, 3'b000,
        orient_q.portrait_landscape_code, orient_q.back_front_code};

    // Read data is registered and held until the next read strobe.

    always_comb begin
        rdata_d = rdata_q;
        if (REG_RD) begin
            case (REG_ADDR)
                `HPFO_ADDR_DATA_CFG: rdata_d = data_cfg_q;
                `HPFO_ADDR_HP_CUT: rdata_d = hp_cut_q;
                `HPFO_ADDR_OR_STAT: rdata_d = stat_word;
                `HPFO_ADDR_OR_CFG: rdata_d = or_cfg_q;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign REG_RDATA = rdata_q;
endmodule

//--- tb/hpfo_regs_properties.sv
// Port checks for the filter/orientation bank.
// Assumes a bind onto hpfo_regs, one clock, synchronous active-low reset.
`timescale 1ns/1ns
// ==========
// Checker
module hpfo_regs_properties
    import hpfo_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RSTN,
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_RDATA,
    input wire hpfo_pkg::hpfo_osr_e OSR_MODE,
    input wire logic [3:0] HP_CUTOFF_SHIFT,
    input wire logic SAMPLE_VALID,
    input wire logic OUT_VALID,
    input wire logic WAKE,
    input wire logic DET_VALID,
    input wire logic DET_OVER_LIMIT,
    input wire logic ORIENT_IRQ_ENABLE,
    input wire logic ORIENT_IRQ_SOURCE,
    input wire logic [7:0] DEBOUNCE_COUNT
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);
    chk_reset_zero: assert property ($rose(RSTN) |-> REG_RDATA == 8'h00
        && DEBOUNCE_COUNT == 8'h00 && !OUT_VALID) else $error("not cleared by reset");
    chk_irq_enable: assert property (!ORIENT_IRQ_ENABLE |-> !ORIENT_IRQ_SOURCE)
        else $error("irq without enable");
    chk_irq_cause: assert property ($rose(ORIENT_IRQ_SOURCE) && $stable(ORIENT_IRQ_ENABLE)
        |-> $past(DET_VALID)) else $error("irq without detection");
    chk_status_clear: assert property (REG_RD && REG_ADDR == 8'h10 && !DET_VALID
        |=> !ORIENT_IRQ_SOURCE) else $error("status read left irq");
    chk_out_follow: assert property (SAMPLE_VALID |=> OUT_VALID)
        else $error("sample not passed");
    chk_out_pulse: assert property (!SAMPLE_VALID |=> !OUT_VALID)
        else $error("spurious out valid");
    chk_over_freeze: assert property (DET_VALID && DET_OVER_LIMIT && $stable(WAKE)
        |=> $stable(DEBOUNCE_COUNT)) else $error("over-limit result used");
    chk_wake_clear: assert property ($changed(WAKE) |-> ##[0:2] DEBOUNCE_COUNT == 8'h00)
        else $error("wake change kept count");
    chk_hires_flat: assert property ((OSR_MODE == HPFO_OSR_HIRES) [*2]
        |-> HP_CUTOFF_SHIFT <= 4'h3) else $error("hires cutoff follows rate");
    cover property (ORIENT_IRQ_SOURCE);
    cover property (OUT_VALID);
    cover property (DEBOUNCE_COUNT == 8'h02);
endmodule
bind hpfo_regs hpfo_regs_properties u_chk (
    .SYS_CLK(SYS_CLK), .RSTN(RSTN), .REG_ADDR(REG_ADDR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .OSR_MODE(OSR_MODE), .HP_CUTOFF_SHIFT(HP_CUTOFF_SHIFT),
    .SAMPLE_VALID(SAMPLE_VALID), .OUT_VALID(OUT_VALID), .WAKE(WAKE), .DET_VALID(DET_VALID),
    .DET_OVER_LIMIT(DET_OVER_LIMIT), .ORIENT_IRQ_ENABLE(ORIENT_IRQ_ENABLE),
    .ORIENT_IRQ_SOURCE(ORIENT_IRQ_SOURCE), .DEBOUNCE_COUNT(DEBOUNCE_COUNT)
);

//--- tb/hpfo_host_model.sv
// Host side of the register strobes: single-byte writes and reads.
// Assumes strobes sampled on the rising edge and read data one cycle later.
`timescale 1ns/1ns
// ==========
// Host model
module hpfo_host_model (
    input wire logic clk,
    output logic [7:0] addr = 8'h00,
    output logic wr = 1'h0,
    output logic rd = 1'h0,
    output logic [7:0] wdata = 8'h00,
    input wire logic [7:0] rdata
);
    // Released lines show the inverse so stale values are never mistaken for good ones.
    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
        addr <= ~a;
        wdata <= ~d;
    endtask
    task automatic rd8(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        addr <= ~a;
        #1;
        d = rdata;
    endtask
endmodule

//--- tb/hpfo_regs_tb_top.sv
// Bench for the filter/orientation bank.
// Assumes the host model and checker bind are compiled first.
`timescale 1ns/1ns
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
    $display("BAD t=%0t %h %h", $time, a, e); end end
// ==========
// Bench
module hpfo_regs_tb_top;
    import hpfo_pkg::*;
    localparam logic [31:0] CUT [4] = '{32'h33332100, 32'h55532100, 32'h0, 32'h66643210};
    logic clk = 1'h0, rstn = 1'h0, sv = 1'h0, act = 1'h0, wake = 1'h0, dv = 1'h0, ovr = 1'h0;
    logic ien = 1'h1, wr, rd, hpb, lpe, ovld, irq;
    logic [2:0] odr = 3'h0;
    hpfo_osr_e osr = HPFO_OSR_NORMAL;
    hpfo_orient_s ori = '0;
    logic [7:0] lim = 8'h02, addr, wd, rdat, cnt;
    logic [3:0] sh;
    hpfo_sample_s osmp;
    int n_errors = 0, n_checks = 0;
    always #2 clk = ~clk;
    hpfo_regs u_dut (.SYS_CLK(clk), .RSTN(rstn), .REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wd),
        .REG_RD(rd), .REG_RDATA(rdat), .ODR_SEL(odr), .OSR_MODE(osr), .HP_CUTOFF_SHIFT(sh),
        .PULSE_HP_BYPASS(hpb), .PULSE_LP_ENABLE(lpe), .SAMPLE_VALID(sv),
        .RAW_SAMPLE(36'h111222333), .HP_SAMPLE(36'hAAABBBCCC), .OUT_SAMPLE(osmp),
        .OUT_VALID(ovld), .ACTIVE(act), .WAKE(wake), .DET_VALID(dv), .DET_ORIENT(ori),
        .DET_OVER_LIMIT(ovr), .DEBOUNCE_LIMIT(lim), .ORIENT_IRQ_ENABLE(ien),
        .ORIENT_IRQ_SOURCE(irq), .DEBOUNCE_COUNT(cnt));
    hpfo_host_model u_host (.clk(clk), .addr(addr), .wr(wr), .rd(rd), .wdata(wd), .rdata(rdat));
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        u_host.rd8(a, v);
        `CHK(v, e)
    endtask
    task automatic det(input logic [3:0] o, input logic ov);
        @(posedge clk);
        ori <= o;
        ovr <= ov;
        dv <= 1'h1;
        @(posedge clk);
        dv <= 1'h0;
    endtask
    task automatic smp(input hpfo_sample_s e);
        @(posedge clk);
        sv <= 1'h1;
        @(posedge clk);
        sv <= 1'h0;
        #1;
        `CHK(ovld, 1'h1)
        `CHK(osmp, e)
    endtask
    task automatic dbc(input logic [7:0] e);
        repeat (2) det(4'h0, 1'h0);
        det(4'h1, 1'h0);
        #1;
        `CHK(cnt, e)
    endtask
    task automatic t_regs();
        rchk(8'h0F, 8'h00);
        rchk(8'h11, 8'h80);
        rchk(8'h10, 8'h00);
        u_host.wr8(8'h0F, 8'hFF);
        rchk(8'h0F, 8'h33);
        `CHK(hpb, 1'h1)
        `CHK(lpe, 1'h1)
        u_host.wr8(8'h10, 8'hFF);
        rchk(8'h10, 8'h00);
        rchk(8'h3F, 8'h00);
    endtask
    task automatic t_cut();
        for (int m = 0; m < 4; m++) begin
            for (int o = 0; o < 8; o++) begin
                @(posedge clk);
                osr <= hpfo_osr_e'(m);
                odr <= 3'(o);
                u_host.wr8(8'h0F, 8'(o % 4));
                repeat (2) @(posedge clk);
                #1;
                `CHK(sh, CUT[m][4*o+:4] + 4'(o % 4))
            end
        end
    endtask
    task automatic t_orient();
        @(posedge clk);
        act <= 1'h1;
        u_host.wr8(8'h11, 8'hC0);
        det(4'h5, 1'h0);
        #1;
        `CHK(irq, 1'h1)
        rchk(8'h10, 8'h85);
        `CHK(irq, 1'h0)
        repeat (2) det(4'hE, 1'h1);
        #1;
        `CHK(cnt, 8'h00)
        repeat (3) det(4'hE, 1'h0);
        rchk(8'h10, 8'hC6);
        repeat (3) det(4'h3, 1'h0);
        #1;
        `CHK(irq, 1'h1)
        @(posedge clk);
        ien <= 1'h0;
        #1;
        `CHK(irq, 1'h0)
        @(posedge clk);
        ien <= 1'h1;
        repeat (3) det(4'h1, 1'h0);
        rchk(8'h10, 8'h81);
        dbc(8'h00);
        u_host.wr8(8'h11, 8'h40);
        dbc(8'h01);
        @(posedge clk);
        wake <= 1'h1;
        repeat (3) @(posedge clk);
        #1;
        `CHK(cnt, 8'h00)
        u_host.wr8(8'h11, 8'h00);
        repeat (4) det(4'h0, 1'h0);
        rchk(8'h10, 8'h01);
    endtask
    task automatic summarize();
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'h1;
        t_regs();
        t_cut();
        u_host.wr8(8'h0E, 8'h10);
        smp(36'hAAABBBCCC);
        u_host.wr8(8'h0E, 8'h00);
        smp(36'h111222333);
        t_orient();
        summarize();
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        summarize();
    end
endmodule
